/* File: rtl/gsca_top.sv */
// Serializer, deserializer and comma word alignment for a ten-bit link
//
// Overview of operation
// - Line bit clock is ten times character clock
// - Transmit character latched each character clock edge
// - Bit zero serialized first, bit nine last
// - Word bits nine..zero are j,h,g,f,i,e,d,c,b,a
// - Two complementary recovered clocks at twentieth rate
// - Receive word updates midway between clock edges
// - Recovered clocks keep running without input
// - Search stream for comma while enabled
// - Misaligned: wrong offset, straddling, or even phase
// - Realign so comma lands on odd phase
// - One character before the comma may repeat or skip
// - Boundary held while alignment disabled
// - Comma flag lasts exactly one character slot
// - Comma flag only active while enabled
// - Earliest received bit lands on bit zero
`timescale 1ns/100ps
`default_nettype none

module gsca_top
  import gsca_pkg::*;
  (
    input  wire logic              ref_clk,
    input  wire logic              rst_n,
    input  wire logic [CHAR_W-1:0] tx_data,
    input  wire logic              tx_valid,
    output logic                   tx_ready,
    output logic                   tx_serial_out,
    input  wire logic              rx_serial_in,
    output logic      [CHAR_W-1:0] rx_data,
    output logic                   recovered_clock_even,
    output logic                   recovered_clock_odd,
    input  wire logic              comma_align_enable,
    output logic                   comma_seen_pulse
  );

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic              char_tick;
  logic              fifo_out_valid;
  logic [CHAR_W-1:0] fifo_out_data;
  logic [CHAR_W-1:0] tx_load_word;
  logic [CHAR_W-1:0] tx_shift_r;
  logic [CHAR_W-1:0] tx_shift_nxt;

  logic              rx_meta_r;
  logic              rx_bit_r;
  logic              en_meta_r;
  logic              en_sync_r;

  logic [HIST_W-1:0] hist_r;
  logic [CNT_W-1:0]  bit_cnt_r;
  logic [CNT_W-1:0]  bit_cnt_nxt;
  logic              rx_phase_r;
  logic              rx_phase_nxt;
  logic              out_phase_r;
  logic [CHAR_W-1:0] rx_data_r;
  logic              comma_pend_r;
  logic              comma_seen_r;
  logic              clk_even_r;

  logic              comma_hit;
  logic              comma_aligned;
  logic              realign;
  logic              char_done;
  logic              clk_edge;

  ////////////////////////////////////////////////////////////////////////////
  // Character rate enable derived from the bit clock
  gsca_div
    #(
      .DIV (LINE_MULT)
    )
    u_char_div
    (
      .clk   (ref_clk),
      .rst_n (rst_n),
      .tick  (char_tick)
    );

  ////////////////////////////////////////////////////////////////////////////
  // Transmit buffer between controller and serializer
  gsca_fifo
    #(
      .WIDTH (CHAR_W),
      .DEPTH (FIFO_DEPTH)
    )
    u_tx_fifo
    (
      .clk       (ref_clk),
      .rst_n     (rst_n),
      .in_valid  (tx_valid),
      .in_ready  (tx_ready),
      .in_data   (tx_data),
      .out_valid (fifo_out_valid),
      .out_ready (char_tick),
      .out_data  (fifo_out_data)
    );

  ////////////////////////////////////////////////////////////////////////////
  // Transmit latch and serializer; fill character when buffer is empty
  assign tx_load_word  = fifo_out_valid ? fifo_out_data : TX_FILL_CHAR;
  assign tx_shift_nxt  = char_tick ? tx_load_word
                                   : {1'b0, tx_shift_r[CHAR_W-1:1]};
  assign tx_serial_out = tx_shift_r[0];

  // Serializer register
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      tx_shift_r <= TX_FILL_CHAR;
    else
      tx_shift_r <= tx_shift_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers for serial input and alignment enable
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_meta_r <= 1'b0;
      rx_bit_r  <= 1'b0;
      en_meta_r <= 1'b0;
      en_sync_r <= 1'b0;
    end
    else
    begin
      rx_meta_r <= rx_serial_in;
      rx_bit_r  <= rx_meta_r;
      en_meta_r <= comma_align_enable;
      en_sync_r <= en_meta_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Comma search and alignment decode
  assign comma_hit     = (hist_r[HIST_W-1 -: COMMA_W] == COMMA_PATTERN);
  assign comma_aligned = (bit_cnt_r == BIT_COMMA_END) && (rx_phase_r == PHASE_ODD);
  assign realign       = en_sync_r && comma_hit && !comma_aligned;
  assign char_done     = (bit_cnt_r == BIT_LAST);
  assign clk_edge      = (bit_cnt_r == BIT_CLK_EDGE);

  // Bit position and phase of the character being assembled
  assign bit_cnt_nxt  = realign   ? BIT_AFTER_COMMA :
                        char_done ? BIT_FIRST : bit_cnt_r + 1'b1;
  assign rx_phase_nxt = realign   ? PHASE_ODD :
                        char_done ? ~rx_phase_r : rx_phase_r;

  ////////////////////////////////////////////////////////////////////////////
  // Deserializer history, newest bit at the top; boundary counted from reset and moved by a realign
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hist_r     <= HIST_RST;
      bit_cnt_r  <= BIT_FIRST;
      rx_phase_r <= PHASE_EVEN;
    end
    else
    begin
      hist_r     <= {rx_bit_r, hist_r[HIST_W-1:1]};
      bit_cnt_r  <= bit_cnt_nxt;
      rx_phase_r <= rx_phase_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pending comma flag for the character in assembly; set wins over clear
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      comma_pend_r <= 1'b0;
    else if (en_sync_r && comma_hit)
      comma_pend_r <= 1'b1;
    else if (char_done)
      comma_pend_r <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive output register, loaded once per character slot
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_data_r    <= RX_DATA_RST;
      out_phase_r  <= PHASE_EVEN;
      comma_seen_r <= 1'b0;
    end
    else if (char_done)
    begin
      rx_data_r    <= hist_r[HIST_W-1:CHAR_W];
      out_phase_r  <= rx_phase_r;
      comma_seen_r <= comma_pend_r && en_sync_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Recovered clocks toggle midway through each output slot; a realign raises
  // the even clock so the comma slot always brings an odd rise, at the cost of
  // one repeated or skipped character just before the comma
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      clk_even_r <= 1'b0;
    else if (realign)
      clk_even_r <= 1'b1;
    else if (clk_edge)
      clk_even_r <= (out_phase_r == PHASE_EVEN);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output drive
  assign rx_data              = rx_data_r;
  assign comma_seen_pulse     = comma_seen_r;
  assign recovered_clock_even = clk_even_r;
  assign recovered_clock_odd  = ~clk_even_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the design's own behaviour
  default clocking cb_ref @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  // Cycles since the last character enable, counted apart from the divider
  logic [CNT_W-1:0] tick_gap_r;

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      tick_gap_r <= '0;
    else if (char_tick)
      tick_gap_r <= '0;
    else
      tick_gap_r <= tick_gap_r + 1'b1;
  end

  // Character enable repeats every ten bit clocks
  property p_char_rate;
    char_tick == (tick_gap_r == CNT_W'(LINE_MULT - 1));
  endproperty
  a_char_rate: assert property (p_char_rate)
    else $error("character enable period is not ten bit clocks");

  // First bit on the line is bit zero of the latched word
  property p_tx_first;
    char_tick |=> (tx_serial_out == $past(tx_load_word[0]));
  endproperty
  a_tx_first: assert property (p_tx_first)
    else $error("bit zero not sent first");

  // Bit nine leaves the line ten cycles after the latch
  property p_tx_last;
    char_tick |-> ##10 (tx_serial_out == $past(tx_load_word[9], 10));
  endproperty
  a_tx_last: assert property (p_tx_last)
    else $error("bit nine not sent last");

  // Recovered clocks only toggle at the mid-slot position or on a realign
  property p_clk_mid;
    $changed(clk_even_r) |-> ($past(bit_cnt_r) == BIT_CLK_EDGE) || $past(realign);
  endproperty
  a_clk_mid: assert property (p_clk_mid)
    else $error("recovered clock toggled off mid-slot");

  // Receive word changes only at a character boundary
  property p_data_slot;
    $changed(rx_data_r) |-> ($past(bit_cnt_r) == BIT_LAST);
  endproperty
  a_data_slot: assert property (p_data_slot)
    else $error("receive word changed inside a slot");

  // Realignment places the next bit after the comma on odd phase
  property p_realign;
    realign |=> (bit_cnt_r == BIT_AFTER_COMMA) && (rx_phase_r == PHASE_ODD);
  endproperty
  a_realign: assert property (p_realign)
    else $error("realignment target wrong");

  // No boundary move while alignment is disabled
  property p_hold;
    !en_sync_r && !char_done |=> (bit_cnt_r == $past(bit_cnt_r) + 4'h1);
  endproperty
  a_hold: assert property (p_hold)
    else $error("boundary moved while alignment disabled");

  // Comma flag lasts a full character slot
  property p_comma_len;
    $rose(comma_seen_pulse) |-> comma_seen_pulse[*8] ##1 comma_seen_pulse ##1 comma_seen_pulse;
  endproperty
  a_comma_len: assert property (p_comma_len)
    else $error("comma flag shorter than one slot");

  // Flagged character holds the comma at bits zero to six
  property p_comma_data;
    $rose(comma_seen_pulse) |-> (rx_data_r[COMMA_W-1:0] == COMMA_PATTERN);
  endproperty
  a_comma_data: assert property (p_comma_data)
    else $error("flagged character lacks an aligned comma");

  // Flagged character is presented on the odd clock phase
  property p_comma_odd;
    comma_seen_pulse && (bit_cnt_r == BIT_AFTER_COMMA) |-> recovered_clock_odd;
  endproperty
  a_comma_odd: assert property (p_comma_odd)
    else $error("comma presented on even clock phase");

  // Comma flag rises only while alignment is enabled
  property p_comma_gate;
    $rose(comma_seen_pulse) |-> $past(en_sync_r);
  endproperty
  a_comma_gate: assert property (p_comma_gate)
    else $error("comma flag while alignment disabled");

  // A flagged comma slot always brings an odd clock rise midway through it
  property p_comma_rise;
    $rose(comma_seen_pulse) |-> ##5 $rose(recovered_clock_odd);
  endproperty
  a_comma_rise: assert property (p_comma_rise)
    else $error("comma slot without an odd clock rise");

endmodule : gsca_top

`default_nettype wire

/* File: include/gsca_pkg.sv */
// Shared constants for the gigabit serdes comma alignment block
`default_nettype none

package gsca_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clocking: ref_clk is the line bit clock, one serial bit per cycle
  localparam int CLK_PERIOD_NS = 20;
  localparam int LINE_MULT     = 10;    // Bit clock to character clock ratio

  ////////////////////////////////////////////////////////////////////////////
  // Character and buffer geometry
  localparam int CHAR_W     = 10;
  localparam int FIFO_DEPTH = 8;
  localparam int HIST_W     = 2 * CHAR_W;
  localparam int CNT_W      = 4;
  localparam int COMMA_W    = 7;

  ////////////////////////////////////////////////////////////////////////////
  // Bit positions within a received character
  localparam logic [CNT_W-1:0] BIT_FIRST       = 4'h0;
  localparam logic [CNT_W-1:0] BIT_CLK_EDGE    = 4'h4;  // Recovered clock toggles here
  localparam logic [CNT_W-1:0] BIT_COMMA_END   = 4'h6;  // Last comma bit when aligned
  localparam logic [CNT_W-1:0] BIT_AFTER_COMMA = 4'h7;
  localparam logic [CNT_W-1:0] BIT_LAST        = 4'h9;

  ////////////////////////////////////////////////////////////////////////////
  // Patterns and reset values
  localparam logic [COMMA_W-1:0] COMMA_PATTERN = 7'h7C;  // 0011111, bit 0 earliest
  localparam logic [CHAR_W-1:0]  TX_FILL_CHAR  = 10'h17C; // Sent while buffer empty
  localparam logic               PHASE_EVEN    = 1'b0;
  localparam logic               PHASE_ODD     = 1'b1;
  localparam logic [HIST_W-1:0]  HIST_RST      = 20'h00000;
  localparam logic [CHAR_W-1:0]  RX_DATA_RST   = 10'h000;

endpackage : gsca_pkg

`default_nettype wire

/* File: rtl/gsca_div.sv */
// Free-running divider producing a one-cycle enable pulse
`timescale 1ns/100ps
`default_nettype none

module gsca_div
  #(
    parameter int DIV = 10
  )
  (
    input  wire logic clk,
    input  wire logic rst_n,
    output logic      tick
  );

  localparam int W = $clog2(DIV);

  logic [W-1:0] cnt_r;

  ////////////////////////////////////////////////////////////////////////////
  // Pulse on the last count of each period
  assign tick = (cnt_r == W'(DIV - 1));

  // Count modulo DIV
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cnt_r <= '0;
    else if (tick)
      cnt_r <= '0;
    else
      cnt_r <= cnt_r + 1'b1;
  end

endmodule : gsca_div

`default_nettype wire

/* File: rtl/gsca_fifo.sv */
// Flip-flop FIFO with valid and ready on both sides
`timescale 1ns/100ps
`default_nettype none

module gsca_fifo
  #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 8
  )
  (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
  );

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [AW:0]      count_r;
  logic             push;
  logic             pop;

  ////////////////////////////////////////////////////////////////////////////
  // Handshake decode
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign in_ready  = (count_r != (AW+1)'(DEPTH));
  assign out_valid = (count_r != '0);
  assign out_data  = mem_r[rd_ptr_r];

  // Storage write
  always_ff @(posedge clk)
  begin
    if (push)
      mem_r[wr_ptr_r] <= in_data;
  end

  // Pointers and fill level
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
      if (pop)
        rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
      if (push && !pop)
        count_r <= count_r + 1'b1;
      else if (pop && !push)
        count_r <= count_r - 1'b1;
    end
  end

endmodule : gsca_fifo

`default_nettype wire

/* File: bench/gsca_ctrl_model.sv */
// Controller model that captures receive characters on both recovered clocks
`timescale 1ns/100ps
`default_nettype none

module gsca_ctrl_model
  import gsca_pkg::*;
  (
    input  wire logic              ref_clk,
    input  wire logic              rst_n,
    input  wire logic [CHAR_W-1:0] rx_data,
    input  wire logic              recovered_clock_even,
    input  wire logic              recovered_clock_odd,
    input  wire logic              comma_seen_pulse,
    output logic                   cap_valid,
    output logic      [CHAR_W-1:0] cap_data,
    output logic                   cap_odd,
    output logic                   cap_flag
  );
  logic      even_r;
  logic      odd_r;
  wire logic even_rise = recovered_clock_even & ~even_r;
  wire logic odd_rise  = recovered_clock_odd & ~odd_r;

  // Edge history matches the reset levels so reset gives no false rise
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      even_r    <= 1'b0;
      odd_r     <= 1'b1;
      cap_valid <= 1'b0;
      cap_data  <= RX_DATA_RST;
      cap_odd   <= 1'b0;
      cap_flag  <= 1'b0;
    end
    else
    begin
      even_r    <= recovered_clock_even;
      odd_r     <= recovered_clock_odd;
      cap_valid <= even_rise | odd_rise;
      cap_data  <= rx_data;
      cap_odd   <= odd_rise;
      cap_flag  <= odd_rise & comma_seen_pulse;
    end
  end
endmodule : gsca_ctrl_model

`default_nettype wire

/* File: bench/testbench.sv */
// Self-checking bench for the serdes comma alignment block
`timescale 1ns/100ps
`default_nettype none

module testbench
  import gsca_pkg::*;
  ;
  logic              ref_clk;
  logic              rst_n;
  logic [CHAR_W-1:0] tx_data;
  logic              tx_valid;
  logic              tx_ready;
  logic              tx_serial_out;
  logic              rx_serial_in;
  logic [CHAR_W-1:0] rx_data;
  logic              rc_even;
  logic              rc_odd;
  logic              comma_align_enable;
  logic              comma_seen_pulse;
  logic              cap_valid;
  logic [CHAR_W-1:0] cap_data;
  logic              cap_odd;
  logic              cap_flag;
  logic [15:0]       seed;
  logic [1:0]        bitq[$];
  logic [11:0]       expq[$];
  logic [9:0]        txq[$];
  logic [9:0]        txw;
  logic              tx_sync;
  logic              rx_sync;
  logic              saw_full;
  int                tx_cnt;
  int                n_fail;
  int                checks;

  gsca_top dut (.ref_clk(ref_clk), .rst_n(rst_n), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_serial_out(tx_serial_out), .rx_serial_in(rx_serial_in),
    .rx_data(rx_data), .recovered_clock_even(rc_even), .recovered_clock_odd(rc_odd),
    .comma_align_enable(comma_align_enable), .comma_seen_pulse(comma_seen_pulse));

  gsca_ctrl_model ctrl (.ref_clk(ref_clk), .rst_n(rst_n), .rx_data(rx_data),
    .recovered_clock_even(rc_even), .recovered_clock_odd(rc_odd),
    .comma_seen_pulse(comma_seen_pulse), .cap_valid(cap_valid), .cap_data(cap_data),
    .cap_odd(cap_odd), .cap_flag(cap_flag));

  ////////////////////////////////////////////////////////////////////////////
  // Shared helpers
  task automatic check(input string name, input logic [11:0] seen, input logic [11:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  function automatic logic [9:0] rnd(input logic [9:0] mask);
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed[9:0] & mask;
  endfunction : rnd

  task automatic print_verdict();
    $display("Comparisons %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : print_verdict

  // Queue one character LSB first, each bit carrying the enable level
  task automatic put_char(input logic [9:0] c, input logic en);
    for (int i = 0; i < 10; i++)
      bitq.push_back({en, c[i]});
  endtask : put_char

  // Hold the word until the edge at which tx_ready is seen high
  task automatic send_tx(input logic [9:0] w);
    tx_data  <= w;
    tx_valid <= 1'b1;
    @(posedge ref_clk);
    while (tx_ready !== 1'b1)
    begin
      saw_full = 1'b1;
      @(posedge ref_clk);
    end
  endtask : send_tx

  ////////////////////////////////////////////////////////////////////////////
  // Clock and watchdog
  initial
  begin
    ref_clk = 1'b0;
    forever #(CLK_PERIOD_NS / 2) ref_clk = ~ref_clk;
  end

  initial
  begin
    #(CLK_PERIOD_NS * 20000);
    n_fail++;
    print_verdict();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial line driver, one bit per cycle; toggles when no input is present
  always @(posedge ref_clk)
  begin
    if (rst_n && bitq.size() > 0)
      {comma_align_enable, rx_serial_in} <= bitq.pop_front();
    else
      rx_serial_in <= ~rx_serial_in;
  end

  // Receive monitor: from the first flagged capture on, compare in order
  always @(posedge ref_clk)
  begin
    if (cap_valid === 1'b1)
    begin
      if (!rx_sync && cap_flag === 1'b1)
        rx_sync = 1'b1;
      if (rx_sync && expq.size() > 0)
        check("rx_char", {cap_flag, cap_odd, cap_data}, expq.pop_front());
    end
  end

  // Transmit monitor: lock on the fill character, then read 10-bit frames
  always @(posedge ref_clk)
  begin
    if (rst_n)
    begin
      txw = {tx_serial_out, txw[9:1]};
      tx_cnt = (tx_cnt == 9) ? 0 : tx_cnt + 1;
      if (!tx_sync && txw === TX_FILL_CHAR)
      begin
        tx_sync = 1'b1;
        tx_cnt = 0;
      end
      else if (tx_sync && tx_cnt == 0 && txw !== TX_FILL_CHAR)
        check("tx_char", {2'b00, txw}, {2'b00, (txq.size() > 0) ? txq.pop_front() : 10'h000});
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    logic [59:0] s;
    logic [9:0]  c;
    logic        prev;
    int          n;
    tx_data = 10'h000;
    tx_valid = 1'b0;
    rx_serial_in = 1'b0;
    comma_align_enable = 1'b0;
    rst_n = 1'b0;
    seed = 16'h000B;
    txw = 10'h000;
    tx_sync = 1'b0;
    rx_sync = 1'b0;
    saw_full = 1'b0;
    tx_cnt = 0;
    n_fail = 0;
    checks = 0;
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    // Misaligned comma on the even slot with alignment on, then aligned data
    bitq.push_back(2'b10);
    bitq.push_back(2'b11);
    bitq.push_back(2'b10);
    for (int i = 0; i < 3; i++)
      put_char(rnd(10'h2DB), 1'b1);
    put_char(TX_FILL_CHAR, 1'b1);
    expq.push_back({2'b11, TX_FILL_CHAR});
    for (int i = 0; i < 8; i++)
    begin
      c = (i == 1) ? TX_FILL_CHAR : rnd(10'h2DB);      // Aligned comma on the odd slot
      put_char(c, i < 4);
      expq.push_back({i == 1, i[0], c});
    end
    // Alignment off: a shifted comma must leave the boundary and flag alone
    s = {7'h2A, rnd(10'h2DB), rnd(10'h2DB), rnd(10'h2DB), rnd(10'h2DB), TX_FILL_CHAR, 3'b010};
    for (int i = 0; i < 60; i++)
      bitq.push_back({1'b0, s[i]});
    for (int k = 0; k < 6; k++)
      expq.push_back({1'b0, k[0], s[10*k +: 10]});
    // Transmit burst that overruns the buffer
    repeat (40) @(posedge ref_clk);
    for (int i = 0; i < 12; i++)
    begin
      c = rnd(10'h3FF);
      if (c == TX_FILL_CHAR)
        c = c ^ 10'h001;
      txq.push_back(c);
      send_tx(c);
    end
    tx_valid <= 1'b0;
    check("tx_full", {11'h000, saw_full}, 12'h001);
    for (int i = 0; i < 3000 && (txq.size() + expq.size() + bitq.size()) > 0; i++)
      @(posedge ref_clk);
    check("tx_left", 12'(txq.size()), 12'h000);
    check("rx_left", 12'(expq.size()), 12'h000);
    $display("Test transmit and receive done");
    // Recovered clocks keep their rate with no input present
    n = 0;
    prev = rc_odd;
    repeat (200)
    begin
      @(posedge ref_clk);
      if (rc_odd === 1'b1 && prev === 1'b0)
        n++;
      prev = rc_odd;
    end
    check("clk_rises", 12'(n), 12'h00A);
    check("clk_compl", {11'h000, rc_even ^ rc_odd}, 12'h001);
    $display("Test recovered clocks done");
    print_verdict();
  end
endmodule : testbench

`default_nettype wire
